// ==== dv/far_node_model.sv ====
// Purpose: Far node on the channel: paces and captures sent headers, sends headers.
// Assumes: One line bit per one-cycle enable, both directions.
// Notes:   Idle receive line toggles so a stale bit never reads as data.
module far_node_model (
    input  wire logic        i_core_clk,
    input  wire logic        i_tx_bit,
    input  wire logic        i_tx_active,
    input  wire logic        i_stall,
    output logic             o_tx_bit_en,
    output logic [39:0]      o_hdr,
    output logic             o_rx_start,
    output logic             o_rx_bit_en,
    output logic             o_rx_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic busy;
    initial begin
        busy = 1'b0;
        o_tx_bit_en = 1'b0;
        o_hdr = 40'h0;
        o_rx_start = 1'b0;
        o_rx_bit_en = 1'b0;
        o_rx_bit = 1'b0;
    end
    // Every other cycle while sending; stall holds the line bit still
    always @(posedge i_core_clk) begin
        if (o_tx_bit_en && i_tx_active) begin
            o_hdr <= {o_hdr[38:0], i_tx_bit};
        end
        o_tx_bit_en <= i_tx_active && !i_stall && !o_tx_bit_en;
        if (!busy) begin
            o_rx_bit <= ~o_rx_bit;
        end
    end
    // Sends the top nbits of h, msb first, with a gap after some bits
    task automatic send(input logic [39:0] h, input int nbits);
        int i;
        @(posedge i_core_clk);
        busy = 1'b1;
        o_rx_start <= 1'b1;
        for (i = 39; i >= 40 - nbits; i--) begin
            @(posedge i_core_clk);
            o_rx_start <= 1'b0;
            o_rx_bit_en <= 1'b1;
            o_rx_bit <= h[i];
            if (i % 3 == 0) begin
                @(posedge i_core_clk);
                o_rx_bit_en <= 1'b0;
            end
        end
        @(posedge i_core_clk);
        o_rx_start <= 1'b0;
        o_rx_bit_en <= 1'b0;
        busy = 1'b0;
    endtask
endmodule

// ==== dv/frame_header_codec_tb.sv ====
// Purpose: Self-checking bench for the frame header codec.
// Assumes: Far node model paces the transmit line.
// Notes:   Expected headers and check codes are built here from field values.
module frame_header_codec_tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic        st;
        logic [3:0]  fl;
        logic [10:0] id;
        logic [6:0]  len;
        logic [6:0]  slen;
        logic [10:0] flip;
        logic [5:0]  cyc;
    } row_t;
    logic clk, rstn, ce, tx_valid, tx_static, stall, tx_en, rx_start, rx_en, rx_bit;
    logic [3:0] fl;
    logic [10:0] tx_id, tx_crc;
    logic [6:0] tx_len, slen;
    logic [5:0] cyc;
    logic o_tx_ready, o_tx_reject, o_tx_bit, o_tx_active, o_tx_done, o_rx_header_valid;
    logic o_rx_crc_error, o_rx_id_error, o_ppi, o_nfi, o_sy, o_su;
    logic [10:0] o_id;
    logic [6:0] o_len;
    logic [5:0] o_cyc;
    logic [39:0] cap, h;
    int n_errors, checks_done, n_done, n_valid, n_crc, n_id, n_rej, vb, cb, ib, db, acc;
    logic ok;
    row_t r;
    // Rows: static flag, flags, id, length, static length, code flip, cycle
    row_t rows [4] = '{
        '{1'b0, 4'hf, 11'h7ff, 7'h7f, 7'h00, 11'h000, 6'h3f},
        '{1'b1, 4'h0, 11'h001, 7'h05, 7'h24, 11'h000, 6'h00},
        '{1'b0, 4'h6, 11'h555, 7'h00, 7'h10, 11'h001, 6'h2a},
        '{1'b1, 4'hb, 11'h2aa, 7'h7f, 7'h7f, 11'h400, 6'h15}};
    frame_header_codec i_dut (.i_core_clk(clk), .i_rstn(rstn), .i_ce(ce),
        .i_tx_valid(tx_valid), .o_tx_ready(o_tx_ready), .i_tx_static(tx_static),
        .i_payload_preamble_flag(fl[3]), .i_null_frame_flag(fl[2]),
        .i_sync_frame_flag(fl[1]), .i_startup_frame_flag(fl[0]), .i_tx_slot_id(tx_id),
        .i_tx_payload_words(tx_len), .i_static_payload_words(slen),
        .i_tx_header_crc(tx_crc), .i_cycle_counter_value(cyc), .o_tx_reject(o_tx_reject),
        .i_tx_bit_en(tx_en), .o_tx_bit(o_tx_bit), .o_tx_active(o_tx_active),
        .o_tx_done(o_tx_done), .i_rx_start(rx_start), .i_rx_bit_en(rx_en),
        .i_rx_bit(rx_bit), .o_rx_header_valid(o_rx_header_valid),
        .o_rx_crc_error(o_rx_crc_error), .o_rx_id_error(o_rx_id_error),
        .o_rx_payload_preamble_flag(o_ppi), .o_rx_null_frame_flag(o_nfi),
        .o_rx_sync_frame_flag(o_sy), .o_rx_startup_frame_flag(o_su), .o_rx_slot_id(o_id),
        .o_rx_payload_words(o_len), .o_rx_cycle_count(o_cyc));
    far_node_model far (.i_core_clk(clk), .i_tx_bit(o_tx_bit), .i_tx_active(o_tx_active),
        .i_stall(stall), .o_tx_bit_en(tx_en), .o_hdr(cap), .o_rx_start(rx_start),
        .o_rx_bit_en(rx_en), .o_rx_bit(rx_bit));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        n_done <= n_done + int'(o_tx_done === 1'b1);
        n_valid <= n_valid + int'(o_rx_header_valid === 1'b1);
        n_crc <= n_crc + int'(o_rx_crc_error === 1'b1);
        n_id <= n_id + int'(o_rx_id_error === 1'b1);
        n_rej <= n_rej + int'(o_tx_reject === 1'b1);
    end
    function automatic logic [10:0] crc11(input logic [19:0] d);
        logic [10:0] c;
        c = 11'h01a;
        for (int k = 19; k >= 0; k--) begin
            c = (c[10] ^ d[k]) ? ({c[9:0], 1'b0} ^ 11'h385) : {c[9:0], 1'b0};
        end
        return c;
    endfunction
    function automatic logic [39:0] hdr(input row_t x);
        logic [6:0] l;
        l = x.st ? x.slen : x.len;
        return {1'b0, x.fl, x.id, l, crc11({x.fl[1:0], x.id, l}) ^ x.flip, x.cyc};
    endfunction
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic wait_for(ref int c, input int target);
        int k;
        for (k = 0; k < 3000 && c < target; k++) begin
            @(posedge clk);
        end
        if (c < target) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, c, target);
            conclude();
        end
    endtask
    task automatic request(input row_t x, output logic taken);
        int k;
        logic [39:0] e;
        e = hdr(x);
        @(posedge clk);
        tx_valid <= 1'b1;
        tx_static <= x.st;
        fl <= x.fl;
        tx_id <= x.id;
        tx_len <= x.len;
        slen <= x.slen;
        tx_crc <= e[16:6];
        cyc <= x.cyc;
        taken = 1'b0;
        for (k = 0; k < 40 && !taken; k++) begin
            @(negedge clk);
            taken = (o_tx_ready === 1'b1);
        end
        @(posedge clk);
        tx_valid <= 1'b0;
    endtask
    task automatic rx_check(input logic [39:0] x, input int nb, input int e_crc);
        vb = n_valid;
        cb = n_crc;
        far.send(x, nb);
        far.send(x, 40);
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk(n_valid - vb, 1);
        chk(n_crc - cb, e_crc);
        chk({o_ppi, o_nfi, o_sy, o_su, o_id, o_len, o_cyc}, {x[38:17], x[5:0]});
    endtask
    initial begin
        {rstn, tx_valid, tx_static, stall, fl, tx_id, tx_len, slen, tx_crc, cyc} = '0;
        ce = 1'b1;
        {n_errors, checks_done, n_done, n_valid, n_crc, n_id, n_rej} = '0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        @(negedge clk);
        chk({o_tx_ready, o_tx_active, o_tx_done, o_rx_header_valid, o_rx_crc_error}, 5'h10);
        foreach (rows[i]) begin
            db = n_done;
            request(rows[i], ok);
            wait_for(n_done, db + 1);
            chk(cap, hdr(rows[i]));
            rx_check(hdr(rows[i]), 0, int'(rows[i].flip != 11'h0));
        end
        rx_check(hdr(rows[0]) | 40'h80_0000_0000, 12, 0);
        r = rows[1];
        r.id = 11'h000;
        ib = n_id;
        rx_check(hdr(r), 0, 0);
        chk(n_id - ib, 1);
        db = n_done;
        cb = n_rej;
        request(r, ok);
        repeat (60) @(posedge clk);
        chk(n_rej - cb, 1);
        chk(n_done - db, 0);
        stall <= 1'b1;
        acc = 0;
        ok = 1'b1;
        while (ok && acc < 8) begin
            r.id = 11'(acc + 1);
            request(r, ok);
            acc += int'(ok);
        end
        chk(acc, 5);
        stall <= 1'b0;
        r.id = 11'(acc);
        wait_for(n_done, db + acc);
        chk(cap, hdr(r));
        // Same identifier again in the same cycle value
        db = n_done;
        cb = n_rej;
        request(r, ok);
        repeat (60) @(posedge clk);
        chk(n_rej - cb, 1);
        chk(n_done - db, 0);
        r.cyc = 6'h01;
        request(r, ok);
        wait_for(n_done, db + 1);
        chk(cap, hdr(r));
        // Clock enable low: nothing taken, sent or received
        ce <= 1'b0;
        vb = n_valid;
        db = n_done;
        r.id = 11'h3c3;
        request(r, ok);
        far.send(hdr(r), 40);
        ce <= 1'b1;
        repeat (60) @(posedge clk);
        chk(n_valid - vb, 0);
        chk(n_done - db, 0);
        conclude();
    end
endmodule

// ==== rtl/frame_header_codec.sv ====
// Purpose: Serialise and check the 5-byte frame header.
// Assumes: Serial bit enables are synchronous to i_core_clk.
// Notes:   Header words are queued in a small FIFO before sending.
`include "frame_header_params.svh"

module hdr_fifo #(
    parameter int WIDTH = 40,
    parameter int DEPTH = 4
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_rstn,
    input  wire logic             i_ce,
    input  wire logic             i_valid,
    output logic                  o_ready,
    input  wire logic [WIDTH-1:0] i_data,
    output logic                  o_valid,
    input  wire logic             i_ready,
    output logic      [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic             push;
    logic             pop;

    assign o_ready = (count != DEPTH[AW:0]);
    assign o_valid = (count != '0);
    assign push    = i_ce && i_valid && o_ready;
    assign pop     = i_ce && o_valid && i_ready;
    assign o_data  = mem[rd_ptr];

    always_ff @(posedge i_core_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_data;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

module frame_header_codec (
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rstn,
    input  wire logic                    i_ce,
    // Transmit request
    input  wire logic                    i_tx_valid,
    output logic                         o_tx_ready,
    input  wire logic                    i_tx_static,
    input  wire logic                    i_payload_preamble_flag,
    input  wire logic                    i_null_frame_flag,
    input  wire logic                    i_sync_frame_flag,
    input  wire logic                    i_startup_frame_flag,
    input  wire logic [`ID_W-1:0]        i_tx_slot_id,
    input  wire logic [`LEN_W-1:0]       i_tx_payload_words,
    input  wire logic [`LEN_W-1:0]       i_static_payload_words,
    input  wire logic [`CRC_W-1:0]       i_tx_header_crc,
    input  wire logic [`CYC_W-1:0]       i_cycle_counter_value,
    output logic                         o_tx_reject,
    // Transmit line
    input  wire logic                    i_tx_bit_en,
    output logic                         o_tx_bit,
    output logic                         o_tx_active,
    output logic                         o_tx_done,
    // Receive line
    input  wire logic                    i_rx_start,
    input  wire logic                    i_rx_bit_en,
    input  wire logic                    i_rx_bit,
    output logic                         o_rx_header_valid,
    output logic                         o_rx_crc_error,
    output logic                         o_rx_id_error,
    output logic                         o_rx_payload_preamble_flag,
    output logic                         o_rx_null_frame_flag,
    output logic                         o_rx_sync_frame_flag,
    output logic                         o_rx_startup_frame_flag,
    output logic [`ID_W-1:0]             o_rx_slot_id,
    output logic [`LEN_W-1:0]            o_rx_payload_words,
    output logic [`CYC_W-1:0]            o_rx_cycle_count
);
    import frame_header_pkg::*;

    // ----------------------------------------------------------------
    // Header check step
    // ----------------------------------------------------------------
    function automatic logic [`CRC_W-1:0] crc_step(input logic [`CRC_W-1:0] crc,
                                                   input logic din);
        logic fb;
        fb = crc[`CRC_W-1] ^ din;
        crc_step = {crc[`CRC_W-2:0], 1'b0} ^ (fb ? `CRC_POLY : 11'h000);
    endfunction

    // ----------------------------------------------------------------
    // Identifier use within one communication cycle
    // ----------------------------------------------------------------
    // Full map costs flops but never refuses a legal slot,
    // unlike a short list of recent identifiers
    logic [(1 << `ID_W)-1:0] id_sent;
    logic [`CYC_W-1:0]       last_cycle;
    logic                    id_repeat;

    assign id_repeat = id_sent[i_tx_slot_id] && (i_cycle_counter_value == last_cycle);

    // ----------------------------------------------------------------
    // Transmit header assembly
    // ----------------------------------------------------------------
    logic [`LEN_W-1:0] tx_len;
    logic              tx_ok;
    header_t           tx_word;
    logic              fifo_valid;
    logic              fifo_ready;
    header_t           fifo_data;
    logic              fifo_in_ready;

    assign tx_len  = i_tx_static ? i_static_payload_words : i_tx_payload_words;
    assign tx_ok   = (i_tx_slot_id != 11'h000) && (tx_len <= `MAX_PAYLOAD_WORDS)
                     && !id_repeat;
    // Reserved bit forced low, check code taken from configuration
    assign tx_word = {1'b0, i_payload_preamble_flag, i_null_frame_flag,
                      i_sync_frame_flag, i_startup_frame_flag, i_tx_slot_id,
                      tx_len, i_tx_header_crc, i_cycle_counter_value};
    assign o_tx_ready = fifo_in_ready;

    hdr_fifo #(.WIDTH(`HDR_BITS), .DEPTH(`FIFO_DEPTH)) u_fifo (
        .i_core_clk (i_core_clk),
        .i_rstn     (i_rstn),
        .i_ce       (i_ce),
        .i_valid    (i_tx_valid && tx_ok),
        .o_ready    (fifo_in_ready),
        .i_data     (tx_word),
        .o_valid    (fifo_valid),
        .i_ready    (fifo_ready),
        .o_data     (fifo_data)
    );

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_tx_reject <= 1'b0;
        end else if (i_ce) begin
            o_tx_reject <= i_tx_valid && fifo_in_ready && !tx_ok;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            last_cycle <= '0;
            id_sent    <= '0;
        end else if (i_ce) begin
            last_cycle <= i_cycle_counter_value;
            // New cycle value starts an empty map
            if (i_cycle_counter_value != last_cycle) begin
                id_sent <= '0;
            end
            // Later assignment wins over the clear above
            if (i_tx_valid && fifo_in_ready && tx_ok) begin
                id_sent[i_tx_slot_id] <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Transmit serialiser
    // ----------------------------------------------------------------
    tx_state_t            tx_state;
    header_t              tx_shift;
    logic [`HDR_CNT_W-1:0] tx_cnt;

    assign fifo_ready  = (tx_state == TX_IDLE);
    assign o_tx_active = (tx_state == TX_SEND);
    assign o_tx_bit    = tx_shift[`HDR_BITS-1];

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tx_state  <= TX_IDLE;
            tx_shift  <= '0;
            tx_cnt    <= '0;
            o_tx_done <= 1'b0;
        end else if (i_ce) begin
            o_tx_done <= 1'b0;
            case (tx_state)
                TX_IDLE: begin
                    if (fifo_valid) begin
                        tx_shift <= fifo_data;
                        tx_cnt   <= '0;
                        tx_state <= TX_SEND;
                    end
                end
                TX_SEND: begin
                    if (i_tx_bit_en) begin
                        // Whole header leaves msb first, field after field
                        tx_shift <= {tx_shift[`HDR_BITS-2:0], 1'b0};
                        if (tx_cnt == 6'(`HDR_BITS - 1)) begin
                            tx_state  <= TX_IDLE;
                            o_tx_done <= 1'b1;
                        end else begin
                            tx_cnt <= tx_cnt + 1'b1;
                        end
                    end
                end
                default: tx_state <= TX_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Receive deserialiser and checker
    // ----------------------------------------------------------------
    header_t               rx_shift;
    header_t               next_rx_shift;
    logic [`HDR_CNT_W-1:0] rx_cnt;
    logic                  rx_busy;
    logic [`CRC_W-1:0]     rx_crc;
    logic                  covered;

    assign next_rx_shift = {rx_shift[`HDR_BITS-2:0], i_rx_bit};
    // Reserved, preamble and null bits are excluded from the check
    assign covered = (rx_cnt >= `COVER_FIRST) && (rx_cnt <= `COVER_LAST);

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rx_busy  <= 1'b0;
            rx_cnt   <= '0;
            rx_shift <= '0;
            rx_crc   <= `CRC_INIT;
        end else if (i_ce) begin
            if (i_rx_start) begin
                rx_busy <= 1'b1;
                rx_cnt  <= '0;
                rx_crc  <= `CRC_INIT;
            end else if (rx_busy && i_rx_bit_en) begin
                rx_shift <= next_rx_shift;
                if (covered) begin
                    rx_crc <= crc_step(rx_crc, i_rx_bit);
                end
                if (rx_cnt == 6'(`HDR_BITS - 1)) begin
                    rx_busy <= 1'b0;
                end
                rx_cnt <= rx_cnt + 1'b1;
            end
        end
    end

    // Check result pulses once the received check field is complete
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rx_crc_error <= 1'b0;
        end else if (i_ce) begin
            o_rx_crc_error <= rx_busy && i_rx_bit_en && !i_rx_start
                && (rx_cnt == `CRC_FIELD_LAST)
                && (next_rx_shift[`CRC_W-1:0] != rx_crc);
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rx_header_valid          <= 1'b0;
            o_rx_id_error              <= 1'b0;
            o_rx_payload_preamble_flag <= 1'b0;
            o_rx_null_frame_flag       <= 1'b0;
            o_rx_sync_frame_flag       <= 1'b0;
            o_rx_startup_frame_flag    <= 1'b0;
            o_rx_slot_id               <= '0;
            o_rx_payload_words         <= '0;
            o_rx_cycle_count           <= '0;
        end else if (i_ce) begin
            o_rx_header_valid <= 1'b0;
            o_rx_id_error     <= 1'b0;
            if (rx_busy && i_rx_bit_en && !i_rx_start && rx_cnt == 6'(`HDR_BITS - 1)) begin
                o_rx_header_valid          <= 1'b1;
                // Reserved bit ignored on receive
                o_rx_payload_preamble_flag <= next_rx_shift[38];
                o_rx_null_frame_flag       <= next_rx_shift[37];
                o_rx_sync_frame_flag       <= next_rx_shift[36];
                o_rx_startup_frame_flag    <= next_rx_shift[35];
                o_rx_slot_id               <= next_rx_shift[34:24];
                o_rx_payload_words         <= next_rx_shift[23:17];
                o_rx_cycle_count           <= next_rx_shift[5:0];
                o_rx_id_error              <= (next_rx_shift[34:24] == 11'h000);
            end
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_last_crc_bit;
        rx_busy && i_ce && i_rx_bit_en && !i_rx_start && rx_cnt == `CRC_FIELD_LAST;
    endsequence

    property p_crc_err;
        @(posedge i_core_clk) disable iff (!i_rstn)
        s_last_crc_bit |=> o_rx_crc_error == ($past(next_rx_shift[10:0]) != $past(rx_crc));
    endproperty
    a_crc_err: assert property (p_crc_err) else $error("crc error mismatch");

    property p_crc_err_only_there;
        @(posedge i_core_clk) disable iff (!i_rstn)
        // Pulse only stretches while the clock enable is low
        o_rx_crc_error |-> !$past(i_ce) || ($past(rx_cnt) == `CRC_FIELD_LAST);
    endproperty
    a_crc_err_only_there: assert property (p_crc_err_only_there) else $error("stray crc err");

    property p_crc_preset;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && i_rx_start) |=> rx_crc == `CRC_INIT;
    endproperty
    a_crc_preset: assert property (p_crc_preset) else $error("crc preset wrong");

    property p_crc_hold;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && rx_busy && i_rx_bit_en && !i_rx_start && !covered) |=> $stable(rx_crc);
    endproperty
    a_crc_hold: assert property (p_crc_hold) else $error("crc moved off cover");

    property p_id_zero;
        @(posedge i_core_clk) disable iff (!i_rstn)
        o_rx_header_valid |-> o_rx_id_error == (o_rx_slot_id == 11'h000);
    endproperty
    a_id_zero: assert property (p_id_zero) else $error("id zero not flagged");

    property p_no_zero_tx;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (fifo_valid && fifo_ready && i_ce) |-> fifo_data[34:24] != 11'h000;
    endproperty
    a_no_zero_tx: assert property (p_no_zero_tx) else $error("zero id queued");

    property p_reserved_low;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && tx_state == TX_IDLE && fifo_valid) |=> o_tx_bit == 1'b0;
    endproperty
    a_reserved_low: assert property (p_reserved_low) else $error("reserved bit high");

    property p_msb_first;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && o_tx_active && i_tx_bit_en && tx_cnt != 6'h27)
            |=> o_tx_bit == $past(tx_shift[38]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("bit order broken");

    property p_static_len;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_tx_static) |-> tx_word[23:17] == i_static_payload_words;
    endproperty
    a_static_len: assert property (p_static_len) else $error("static length wrong");

    property p_repeat_rejected;
        @(posedge i_core_clk) disable iff (!i_rstn)
        (i_ce && i_tx_valid && fifo_in_ready && id_repeat) |=> o_tx_reject;
    endproperty
    a_repeat_rejected: assert property (p_repeat_rejected) else $error("id repeated");

    property p_done_last;
        @(posedge i_core_clk) disable iff (!i_rstn)
        o_tx_done |-> (tx_state == TX_IDLE) && (tx_cnt == 6'(`HDR_BITS - 1));
    endproperty
    a_done_last: assert property (p_done_last) else $error("done before last bit");

    property p_ce_freeze;
        @(posedge i_core_clk) disable iff (!i_rstn)
        !i_ce |=> $stable(tx_state) && $stable(tx_cnt) && $stable(rx_cnt) && $stable(rx_crc);
    endproperty
    a_ce_freeze: assert property (p_ce_freeze) else $error("state moved while frozen");
endmodule

// ==== rtl/frame_header_params.svh ====
// Purpose: Constants for the frame header codec.
// Assumes: One 200 MHz core clock.
// Notes:   Field widths, CRC polynomial and preset.
//
// Overview of operation
// - Slot identifier is 11 bits; valid sent values are 1 to 2047.
// - Identifier zero is never transmitted.
// - Received identifier zero is always flagged erroneous.
// - Each identifier appears at most once per cycle on a channel.
// - Identifier bits go out most significant first.
// - Payload length field holds payload bytes halved, header and trailer excluded.
// - Payload length ranges from zero to the maximum word count.
// - Maximum payload is 127 words, an even byte count up to 254.
// - Static segment frames all carry the configured static word count.
// - Dynamic frames may use differing lengths per cycle and channel.
// - Payload length bits go out most significant first.
// - Header check covers sync, startup, identifier and length, 20 bits.
// - Transmit inserts a configured header check, never computed.
// - Receive computes the header check and compares it.
// - Header check polynomial is x11+x9+x8+x7+x2+1.
// - Header check register is preset to 0x01a.
// - Check input order: sync, startup, identifier, then length, msb first.
// - Header check field goes out most significant first.
// - Six-bit cycle count carries the current cycle counter value.
// - Cycle count bits go out most significant first.
// - Header field order: reserved, preamble, null, sync, startup, id, len, crc, cycle.
// - Header is 5 bytes; reserved sent as zero, accepted either way.
`ifndef FRAME_HEADER_PARAMS_SVH
`define FRAME_HEADER_PARAMS_SVH
`define HDR_BITS        40
`define HDR_CNT_W       6
`define ID_W            11
`define LEN_W           7
`define CRC_W           11
`define CYC_W           6
`define MAX_PAYLOAD_WORDS 7'h7f
`define CRC_POLY        11'h385
`define CRC_INIT        11'h01a
`define COVER_FIRST     6'h03
`define COVER_LAST      6'h16
`define CRC_FIELD_LAST  6'h21
`define FIFO_DEPTH      4
`endif

// ==== rtl/frame_header_pkg.sv ====
// Purpose: Types for the frame header codec.
// Assumes: Constants come from the params header.
// Notes:   States are Gray coded.
package frame_header_pkg;
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SEND = 2'b01
    } tx_state_t;
    typedef logic [39:0] header_t;
endpackage
